// File: shared/rwa_pkg.sv
// Notes on behaviour
// - SONET size select picks 16 or 32-bit pattern
// - In bit-slip mode each slip request rising edge slips one bit
// - Enable edge-sensitive at 8 bits, level at 10
// - Polarity input inverts every incoming word bit
// - Basic bit-slip mode may reverse output bit order
// - Current slipped bit count is always visible
// - Pattern detect high when pattern on boundary
// - Pattern detect one bit, or two when double width
// - Asynchronous control inputs are synchronised first
// - Manual mode sync pulse one cycle, none in slip
// - Run-length violation pulse lasts at least two or three clocks
package rwa_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int RWA_WORD_MAX = 20;
   localparam int RWA_BYTE_MAX = 10;
   localparam logic [4:0] RWA_BYTE_NARROW = 5'h08;
   localparam logic [4:0] RWA_BYTE_WIDE = 5'h0A;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] RWA_OFF_CTRL = 8'h00;
   localparam logic [7:0] RWA_OFF_PATTERN = 8'h04;
   localparam logic [7:0] RWA_OFF_RUN_LIMIT = 8'h08;
   localparam logic [7:0] RWA_OFF_STATE = 8'h0C;
   localparam logic [7:0] RWA_OFF_IRQ_STATUS = 8'h10;
   localparam logic [7:0] RWA_OFF_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] RWA_OFF_IRQ_CLEAR = 8'h18;

   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int RWA_CTRL_SLIP_MODE = 0;
   localparam int RWA_CTRL_WIDTH_LSB = 1;
   localparam int RWA_CTRL_SONET = 3;
   localparam int RWA_CTRL_BYTE_SER = 4;
   localparam int RWA_CTRL_BITS = 5;

   // ************************************************************
   // State register fields
   // ************************************************************
   localparam int RWA_ST_SLIP_LSB = 0;
   localparam int RWA_ST_DETECT_LSB = 5;
   localparam int RWA_ST_SYNC_LSB = 7;
   localparam int RWA_ST_HUNT = 9;
   localparam int RWA_ST_LOCK = 10;
   localparam int RWA_ST_RUN_VIOL = 11;

   // ************************************************************
   // Interrupt events
   // ************************************************************
   localparam int RWA_IRQ_DETECT = 0;
   localparam int RWA_IRQ_SYNC = 1;
   localparam int RWA_IRQ_RUN_VIOL = 2;
   localparam int RWA_IRQ_SLIP = 3;
   localparam int RWA_IRQ_BITS = 4;

   // ************************************************************
   // Reset values and counts
   // ************************************************************
   localparam logic [RWA_CTRL_BITS-1:0] RWA_CTRL_RESET = 5'h00;
   localparam logic [31:0] RWA_PATTERN_RESET = 32'h0000_F628;
   localparam logic [7:0] RWA_RUN_LIMIT_RESET = 8'h28;
   localparam logic [1:0] RWA_RUN_HOLD_PLAIN = 2'h2;
   localparam logic [1:0] RWA_RUN_HOLD_SER = 2'h3;

   typedef enum logic [1:0] {RWA_IDLE, RWA_HUNT, RWA_LOCKED} rwa_search_type;

endpackage

// File: logic/rwa_sync.sv
module rwa_sync #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// File: logic/rwa_aligner.sv
module rwa_aligner import rwa_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_digital_reset,
   input wire logic [19:0] rx_word,
   input wire logic sonet_pattern_size_select,
   input wire logic slip_request,
   input wire logic manual_align_enable,
   input wire logic polarity_invert,
   input wire logic bit_reverse,
   output logic [19:0] aligned_word,
   output logic [1:0] pattern_detect,
   output logic [1:0] sync_status,
   output logic [4:0] slip_count,
   output logic run_length_violation,
   output logic irq
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [19:0] f_mask(input logic [4:0] n);
      logic [19:0] m;
      m = 20'h0;
      for (int i = 0; i < 20; i++) begin
         m[i] = (5'(i) < n);
      end
      return m;
   endfunction

   function automatic logic f_match(input logic [9:0] s0, input logic [9:0] s1,
                                    input logic [9:0] s2, input logic [9:0] s3,
                                    input logic [2:0] len, input logic [4:0] bw,
                                    input logic [31:0] pat, input logic [9:0] bm);
      logic ok;
      ok = (s0 == (10'(pat) & bm));
      if (len > 3'h1) begin
         ok = ok && (s1 == (10'(pat >> bw) & bm));
      end
      if (len > 3'h2) begin
         ok = ok && (s2 == (10'(pat >> (2 * int'(bw))) & bm));
         ok = ok && (s3 == (10'(pat >> (3 * int'(bw))) & bm));
      end
      return ok;
   endfunction

   function automatic logic [19:0] f_reverse(input logic [19:0] d, input logic [4:0] bw,
                                              input logic dbl);
      logic [19:0] r;
      r = 20'h0;
      for (int i = 0; i < RWA_BYTE_MAX; i++) begin
         if (i < int'(bw)) begin
            r[i] = d[int'(bw) - 1 - i];
            if (dbl) begin
               r[int'(bw) + i] = d[2 * int'(bw) - 1 - i];
            end
         end
      end
      return r;
   endfunction

   // ************************************************************
   // Control input synchronisation
   // ************************************************************
   logic [4:0] ctl_s;
   logic size_s, rev_s, inv_s, en_s, slip_s;
   logic slip_dly_q, slip_dly_d, en_dly_q, en_dly_d;

   rwa_sync #(.WIDTH(5)) u_ctl_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({sonet_pattern_size_select, bit_reverse, polarity_invert,
                 manual_align_enable, slip_request}),
      .sync_out(ctl_s)
   );
   assign {size_s, rev_s, inv_s, en_s, slip_s} = ctl_s;

   // ************************************************************
   // Registers
   // ************************************************************
   logic [RWA_CTRL_BITS-1:0] ctrl_q, ctrl_d;
   logic [31:0] pattern_q, pattern_d;
   logic [7:0] limit_q, limit_d;
   logic [RWA_IRQ_BITS-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, irq_clr;
   logic [RWA_IRQ_BITS-1:0] events;
   logic [31:0] prdata_q, prdata_d, rd_val;
   logic addr_hit, wr_acc;
   rwa_search_type state_q, state_d;

   always_comb begin
      addr_hit = 1'b1;
      rd_val = 32'h0;
      unique case (paddr)
         RWA_OFF_CTRL: rd_val = {27'h0, ctrl_q};
         RWA_OFF_PATTERN: rd_val = pattern_q;
         RWA_OFF_RUN_LIMIT: rd_val = {24'h0, limit_q};
         RWA_OFF_STATE: rd_val = {20'h0, run_length_violation, state_q == RWA_LOCKED,
                                  state_q == RWA_HUNT, sync_status, pattern_detect,
                                  slip_count};
         RWA_OFF_IRQ_STATUS: rd_val = {28'h0, irq_stat_q};
         RWA_OFF_IRQ_ENABLE: rd_val = {28'h0, irq_en_q};
         RWA_OFF_IRQ_CLEAR: rd_val = 32'h0;
         default: addr_hit = 1'b0;
      endcase
      wr_acc = psel && penable && pwrite && addr_hit;
      ctrl_d = ctrl_q;
      pattern_d = pattern_q;
      limit_d = limit_q;
      irq_en_d = irq_en_q;
      irq_clr = '0;
      if (wr_acc) begin
         unique case (paddr)
            RWA_OFF_CTRL: ctrl_d = pwdata[RWA_CTRL_BITS-1:0];
            RWA_OFF_PATTERN: pattern_d = pwdata;
            RWA_OFF_RUN_LIMIT: limit_d = pwdata[7:0];
            RWA_OFF_IRQ_ENABLE: irq_en_d = pwdata[RWA_IRQ_BITS-1:0];
            RWA_OFF_IRQ_CLEAR: irq_clr = pwdata[RWA_IRQ_BITS-1:0];
            default: ;
         endcase
      end
      // A fresh event outranks a clear in the same cycle
      irq_stat_d = (irq_stat_q & ~irq_clr) | events;
      prdata_d = (psel && !penable && !pwrite) ? rd_val : prdata_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= RWA_CTRL_RESET;
         pattern_q <= RWA_PATTERN_RESET;
         limit_q <= RWA_RUN_LIMIT_RESET;
         irq_stat_q <= '0;
         irq_en_q <= '0;
         prdata_q <= 32'h0;
      end else begin
         ctrl_q <= ctrl_d;
         pattern_q <= pattern_d;
         limit_q <= limit_d;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= irq_en_d;
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   assign irq = |(irq_stat_q & irq_en_q);

   // ************************************************************
   // Alignment datapath
   // ************************************************************
   logic [4:0] off_q, off_d, byte_w, word_w, cand;
   logic [19:0] prev_q, prev_d, cur_m, wmask, aligned_pre, out_d;
   logic [39:0] win;
   logic [9:0] bmask, ab0, ab1, pb0;
   logic [9:0] h0_q, h1_q, h2_q, h0_d, h1_d, h2_d;
   logic [2:0] pat_len;
   logic [1:0] pd, sync_d;
   logic slip_mode, dbl, level_mode, start, en_rise, slip_rise, hit;

   always_comb begin
      slip_mode = ctrl_q[RWA_CTRL_SLIP_MODE];
      dbl = ctrl_q[RWA_CTRL_WIDTH_LSB + 1];
      byte_w = ctrl_q[RWA_CTRL_WIDTH_LSB] ? RWA_BYTE_WIDE : RWA_BYTE_NARROW;
      word_w = dbl ? 5'(byte_w << 1) : byte_w;
      wmask = f_mask(word_w);
      bmask = 10'(f_mask(byte_w));
      // Inversion ahead of all alignment work
      cur_m = (rx_word ^ {20{inv_s}}) & wmask;
      // Two words side by side let any boundary offset be extracted
      win = ({20'h0, cur_m} << word_w) | {20'h0, prev_q};
      aligned_pre = 20'(win >> off_q) & wmask;
      ab0 = 10'(aligned_pre) & bmask;
      ab1 = 10'(aligned_pre >> byte_w) & bmask;
      // Larger patterns only under SONET framing
      if (ctrl_q[RWA_CTRL_SONET]) begin
         pat_len = size_s ? 3'h4 : 3'h2;
      end else begin
         pat_len = 3'h1;
      end
      pd[0] = f_match(ab0, h0_q, h1_q, h2_q, pat_len, byte_w, pattern_q, bmask);
      pd[1] = dbl && f_match(ab1, ab0, h0_q, h1_q, pat_len, byte_w, pattern_q,
                             bmask);
      // Search looks for the last byte of the pattern at every offset at once
      pb0 = 10'(pattern_q) & bmask;
      hit = 1'b0;
      cand = 5'h0;
      for (int o = 0; o < RWA_WORD_MAX; o++) begin
         if (5'(o) < word_w && !hit && ((10'(win >> o) & bmask) == pb0)) begin
            hit = 1'b1;
            cand = 5'(o);
         end
      end
      out_d = (ctrl_q[RWA_CTRL_SONET] == 1'b0 && slip_mode && rev_s) ?
              f_reverse(aligned_pre, byte_w, dbl) : aligned_pre;
      prev_d = cur_m;
      if (dbl) begin
         h0_d = ab1;
         h1_d = ab0;
         h2_d = h0_q;
      end else begin
         h0_d = ab0;
         h1_d = h0_q;
         h2_d = h1_q;
      end
   end

   // ************************************************************
   // Boundary control
   // ************************************************************
   always_comb begin
      // Pulse width of two clocks from the far side keeps these edges visible
      slip_rise = slip_s && !slip_dly_q;
      en_rise = en_s && !en_dly_q;
      slip_dly_d = slip_s;
      en_dly_d = en_s;
      level_mode = (byte_w == RWA_BYTE_WIDE);
      start = level_mode ? en_s : en_rise;
      state_d = state_q;
      off_d = off_q;
      sync_d = 2'h0;
      if (slip_mode) begin
         state_d = RWA_IDLE;
         if (slip_rise) begin
            off_d = (off_q >= word_w - 5'h1) ? 5'h0 : off_q + 5'h1;
         end
      end else begin
         unique case (state_q)
            RWA_IDLE: begin
               if (start) begin
                  state_d = RWA_HUNT;
               end
            end
            RWA_HUNT: begin
               if (level_mode && !en_s) begin
                  state_d = RWA_IDLE;
               end else if (|pd) begin
                  state_d = RWA_LOCKED;
                  sync_d = pd;
               end else if (hit) begin
                  off_d = cand;
               end
            end
            RWA_LOCKED: begin
               if (level_mode && !en_s) begin
                  state_d = RWA_IDLE;
               end else if (!level_mode && en_rise) begin
                  state_d = RWA_HUNT;
               end
            end
         endcase
      end
      if (off_d >= word_w) begin
         off_d = 5'h0;
      end
      if (rx_digital_reset) begin
         state_d = RWA_IDLE;
         off_d = 5'h0;
         sync_d = 2'h0;
      end
   end

   // ************************************************************
   // Run-length check
   // ************************************************************
   logic [7:0] run_q, run_d;
   logic last_q, last_d, viol;
   logic [1:0] hold_q, hold_d;

   always_comb begin
      run_d = run_q;
      last_d = last_q;
      viol = 1'b0;
      // Oldest bit first, counting across word edges
      for (int i = 0; i < RWA_WORD_MAX; i++) begin
         if (5'(i) < word_w) begin
            if (cur_m[i] == last_d) begin
               run_d = (run_d == 8'hFF) ? run_d : run_d + 8'h01;
            end else begin
               run_d = 8'h01;
            end
            last_d = cur_m[i];
            if (run_d > limit_q) begin
               viol = 1'b1;
            end
         end
      end
      if (viol) begin
         hold_d = ctrl_q[RWA_CTRL_BYTE_SER] ? RWA_RUN_HOLD_SER : RWA_RUN_HOLD_PLAIN;
      end else begin
         hold_d = (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
      end
      if (rx_digital_reset) begin
         run_d = 8'h0;
         hold_d = 2'h0;
      end
      events = '0;
      events[RWA_IRQ_DETECT] = |pd;
      events[RWA_IRQ_SYNC] = |sync_d;
      events[RWA_IRQ_RUN_VIOL] = viol;
      events[RWA_IRQ_SLIP] = slip_mode && slip_rise;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= RWA_IDLE;
         off_q <= 5'h0;
         prev_q <= 20'h0;
         h0_q <= 10'h0;
         h1_q <= 10'h0;
         h2_q <= 10'h0;
         slip_dly_q <= 1'b0;
         en_dly_q <= 1'b0;
         run_q <= 8'h0;
         last_q <= 1'b0;
         hold_q <= 2'h0;
         aligned_word <= 20'h0;
         pattern_detect <= 2'h0;
         sync_status <= 2'h0;
         run_length_violation <= 1'b0;
      end else begin
         state_q <= state_d;
         off_q <= off_d;
         prev_q <= rx_digital_reset ? 20'h0 : prev_d;
         h0_q <= rx_digital_reset ? 10'h0 : h0_d;
         h1_q <= rx_digital_reset ? 10'h0 : h1_d;
         h2_q <= rx_digital_reset ? 10'h0 : h2_d;
         slip_dly_q <= slip_dly_d;
         en_dly_q <= en_dly_d;
         run_q <= run_d;
         last_q <= last_d;
         hold_q <= hold_d;
         aligned_word <= rx_digital_reset ? 20'h0 : out_d;
         pattern_detect <= rx_digital_reset ? 2'h0 : pd;
         sync_status <= sync_d;
         run_length_violation <= (hold_d != 2'h0);
      end
   end

   // Offset is live so user logic can follow each slip
   assign slip_count = off_q;

endmodule

// File: verification/rwa_fabric_model.sv
module rwa_fabric_model import rwa_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slip_go,
   input wire logic align_go,
   input wire logic pol_req,
   input wire logic rev_req,
   input wire logic size_req,
   output logic slip_request,
   output logic manual_align_enable,
   output logic polarity_invert,
   output logic bit_reverse,
   output logic sonet_pattern_size_select
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Fabric side pulses, three clocks long to clear the two-clock minimum
   // ************************************************************
   logic [1:0] slip_left_q;
   logic [1:0] align_left_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slip_left_q <= 2'h0;
         align_left_q <= 2'h0;
         polarity_invert <= 1'b0;
         bit_reverse <= 1'b0;
         sonet_pattern_size_select <= 1'b0;
      end else begin
         slip_left_q <= slip_go ? 2'h3 : slip_left_q - {1'b0, |slip_left_q};
         align_left_q <= align_go ? 2'h3 : align_left_q - {1'b0, |align_left_q};
         polarity_invert <= pol_req;
         bit_reverse <= rev_req;
         sonet_pattern_size_select <= size_req;
      end
   end
   assign slip_request = slip_left_q != 2'h0;
   assign manual_align_enable = align_left_q != 2'h0;
endmodule

// File: verification/rwa_aligner_assertions.sv
module rwa_aligner_checker import rwa_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input logic pready,
   input logic pslverr,
   input wire logic rx_digital_reset,
   input wire logic slip_request,
   input logic [1:0] pattern_detect,
   input logic [1:0] sync_status,
   input logic [4:0] slip_count,
   input logic run_length_violation
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY: assert property (pready)
      else $error("pready low");
   AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   AST_UNMAPPED: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
      else $error("unmapped access not refused");
   AST_DIG_RESET: assert property (rx_digital_reset |=> slip_count == 5'h00 &&
      sync_status == 2'h0 && pattern_detect == 2'h0) else $error("digital reset ignored");
   AST_SLIP_RANGE: assert property (slip_count <= 5'h13)
      else $error("slip count out of range");
   // Synchroniser delay: a fresh request must not move the boundary at once
   AST_SLIP_SYNC: assert property ($rose(slip_request) |=> $stable(slip_count))
      else $error("slip acted before synchronisation");
   AST_SYNC_PULSE: assert property (|sync_status |=> sync_status == 2'h0)
      else $error("sync pulse longer than one cycle");
   AST_SYNC_DETECT: assert property (|sync_status |-> |pattern_detect)
      else $error("sync without pattern detect");
   AST_RLV_MIN: assert property ($rose(run_length_violation) && !rx_digital_reset
      |=> run_length_violation) else $error("run violation pulse too short");
endmodule

bind rwa_aligner rwa_aligner_checker rwa_aligner_checker_inst (.pclk, .presetn, .paddr,
   .psel, .penable, .pready, .pslverr, .rx_digital_reset, .slip_request, .pattern_detect,
   .sync_status, .slip_count, .run_length_violation);

// File: verification/rwa_aligner_test.sv
module rwa_aligner_test import rwa_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic err;} rwa_row_type;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_digital_reset, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] rx_word, aligned_word, word_fill, pair_a, pair_b;
   logic [1:0] pattern_detect, sync_status;
   logic [4:0] slip_count;
   logic run_length_violation, alt, slip_go, align_go, pol_req, rev_req, size_req;
   logic slip_request, manual_align_enable, polarity_invert, bit_reverse, sonet_pattern_size_select;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int n, i;
   // Register rows run while the digital reset holds the stream still
   rwa_row_type rows [12] = '{'{8'h00, 0, 0, 0, 0}, '{8'h04, 0, 0, 32'hF628, 0},
      '{8'h08, 0, 0, 32'h28, 0}, '{8'h0C, 0, 0, 0, 0}, '{8'h10, 0, 0, 0, 0},
      '{8'h14, 0, 0, 0, 0}, '{8'h18, 0, 0, 0, 0}, '{8'h1C, 0, 0, 0, 1},
      '{8'h0C, 1, 32'hFFF, 0, 0}, '{8'h08, 1, 32'h3C, 32'h3C, 0},
      '{8'h08, 1, 32'h28, 32'h28, 0}, '{8'h1C, 1, 32'h5, 0, 1}};

   rwa_aligner rwa_aligner_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .rx_digital_reset, .rx_word, .sonet_pattern_size_select,
      .slip_request, .manual_align_enable, .polarity_invert, .bit_reverse, .aligned_word,
      .pattern_detect, .sync_status, .slip_count, .run_length_violation, .irq);
   rwa_fabric_model rwa_fabric_model_inst (.pclk, .presetn, .slip_go, .align_go, .pol_req,
      .rev_req, .size_req, .slip_request, .manual_align_enable, .polarity_invert,
      .bit_reverse, .sonet_pattern_size_select);

   // ************************************************************
   // Clock, stream and watchdog
   // ************************************************************
   always #4 pclk = ~pclk;
   // Alternating words put the one-byte pattern only at offset 3
   always @(posedge pclk) rx_word <= alt ? (rx_word == pair_a ? pair_b : pair_a) : word_fill;
   always @(posedge pclk) begin
      cycles++;
      if (cycles >= 5000) begin
         failures++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb_rw(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   function automatic logic [7:0] exp_word(input logic [7:0] w, input int s, input logic inv,
      input logic rev);
      logic [15:0] win;
      logic [7:0] b;
      logic [7:0] r;
      win = inv ? ~{w, w} : {w, w};
      b = 8'(win >> s);
      for (int k = 0; k < 8; k++) r[k] = b[7 - k];
      return rev ? r : b;
   endfunction

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      {pclk, presetn, psel, penable, pwrite, alt, slip_go, align_go} = 8'h00;
      {pol_req, rev_req, size_req} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rx_digital_reset = 1'b1;
      word_fill = 20'hA5;
      pair_a = 20'h40;
      pair_b = 20'h1;
      rx_word = 20'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[k]) begin
         if (rows[k].w) apb_rw(rows[k].a, 1'b1, rows[k].d, rd, err);
         if (rows[k].w) chk(32'(err), 32'(rows[k].err));
         apb_rw(rows[k].a, 1'b0, 32'h0, rd, err);
         chk(rd, rows[k].e);
         chk(32'(err), 32'(rows[k].err));
      end
      apb_rw(RWA_OFF_CTRL, 1'b1, 32'h1, rd, err);
      apb_rw(RWA_OFF_IRQ_ENABLE, 1'b1, 32'h8, rd, err);
      @(posedge pclk) rx_digital_reset <= 1'b0;
      for (i = 1; i <= 3; i++) begin
         @(posedge pclk) slip_go <= 1'b1;
         @(posedge pclk) slip_go <= 1'b0;
         repeat (10) @(negedge pclk);
         chk(32'(slip_count), 32'(i));
      end
      chk(32'(irq), 32'h1);
      apb_rw(RWA_OFF_IRQ_ENABLE, 1'b1, 32'h0, rd, err);
      chk(32'(irq), 32'h0);
      apb_rw(RWA_OFF_IRQ_ENABLE, 1'b1, 32'h8, rd, err);
      apb_rw(RWA_OFF_IRQ_CLEAR, 1'b1, 32'h8, rd, err);
      chk(32'(irq), 32'h0);
      apb_rw(RWA_OFF_IRQ_STATUS, 1'b0, 32'h0, rd, err);
      chk(rd, 32'h0);
      for (i = 0; i < 4; i++) begin
         @(posedge pclk);
         pol_req <= i[0];
         rev_req <= i[1];
         repeat (8) @(negedge pclk);
         chk(32'(aligned_word), 32'(exp_word(8'hA5, 3, i[0], i[1])));
      end
      // Six constant words make one 48-bit run, just past the threshold of forty
      @(posedge pclk) word_fill <= 20'h0;
      repeat (6) @(posedge pclk);
      word_fill <= 20'hA5;
      n = 0;
      while (run_length_violation !== 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      i = 0;
      while (run_length_violation === 1'b1 && i < 10) begin
         @(negedge pclk);
         i++;
      end
      chk(32'(i), 32'(RWA_RUN_HOLD_PLAIN));
      // Inversion would hide the alignment pattern below; reversal only alters aligned_word in slip mode
      @(posedge pclk) {pol_req, rev_req} <= 2'h0;
      apb_rw(RWA_OFF_CTRL, 1'b1, 32'h0, rd, err);
      @(posedge pclk) rx_digital_reset <= 1'b1;
      @(posedge pclk) rx_digital_reset <= 1'b0;
      alt <= 1'b1;
      size_req <= 1'b1;
      repeat (4) @(posedge pclk);
      align_go <= 1'b1;
      @(posedge pclk) align_go <= 1'b0;
      n = 0;
      while (sync_status[0] !== 1'b1 && n < 80) begin
         @(negedge pclk);
         n++;
      end
      chk(32'(sync_status), 32'h1);
      chk(32'(slip_count), 32'h3);
      chk(32'(pattern_detect), 32'h1);
      @(posedge pclk) rx_digital_reset <= 1'b1;
      @(posedge pclk) rx_digital_reset <= 1'b0;
      @(negedge pclk);
      chk(32'(slip_count), 32'h0);
      // Two-byte framing locks under SONET; the four-byte choice must then refuse it
      apb_rw(RWA_OFF_CTRL, 1'b1, 32'h8, rd, err);
      @(posedge pclk) rx_digital_reset <= 1'b1;
      pair_a <= 20'hF6;
      pair_b <= 20'h28;
      size_req <= 1'b0;
      @(posedge pclk) rx_digital_reset <= 1'b0;
      repeat (4) @(posedge pclk);
      align_go <= 1'b1;
      @(posedge pclk) align_go <= 1'b0;
      n = 0;
      while (sync_status[0] !== 1'b1 && n < 80) begin
         @(negedge pclk);
         n++;
      end
      chk(32'(sync_status), 32'h1);
      chk(32'(slip_count), 32'h0);
      @(posedge pclk) size_req <= 1'b1;
      repeat (6) @(negedge pclk);
      chk(32'(pattern_detect), 32'h0);
      @(negedge pclk);
      chk(32'(pattern_detect), 32'h0);
      conclude();
   end
endmodule
